// [hw/pfc_pkg.sv]
package pfc_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  typedef logic [ADDR_W-1:0] pfc_addr_t;
  typedef logic [DATA_W-1:0] pfc_data_t;

  // Word address where configuration data starts after a full reset
  localparam pfc_addr_t BOOT_ADDR_DEFAULT = 24'h010000;

  // Timing: system clock, slowest legal and typical configuration clock
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CFG_CLK_MAX_PERIOD_NS = 50;
  localparam int CFG_CLK_TYP_PERIOD_PS = 33330;
  localparam int CFG_CLK_MAX_CYC = (CFG_CLK_MAX_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int CFG_CLK_TYP_CYC = (CFG_CLK_TYP_PERIOD_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  // Even divider nearest the typical period, so both halves are whole cycles
  localparam int CFG_CLK_DIV_RAW = ((CFG_CLK_TYP_CYC + 1) / 2) * 2;
  localparam int CFG_CLK_DIV = (CFG_CLK_DIV_RAW > CFG_CLK_MAX_CYC) ?
                               CFG_CLK_MAX_CYC - (CFG_CLK_MAX_CYC % 2) : CFG_CLK_DIV_RAW;
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_HIGH = 3'(CFG_CLK_DIV / 2);
  localparam logic [PHASE_W-1:0] PHASE_LAST = 3'(CFG_CLK_DIV - 1);

  typedef struct packed {
    pfc_addr_t addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic avd_n;
    logic rst_n;
  } pfc_flash_bus_t;

  localparam pfc_flash_bus_t FLASH_BUS_IDLE = '{addr: '0, ce_n: 1'b1, oe_n: 1'b1,
                                                we_n: 1'b1, avd_n: 1'b1, rst_n: 1'b1};

  typedef struct packed {
    pfc_addr_t addr;
    pfc_data_t data;
  } pfc_word_t;

  typedef enum logic {ST_RELEASED, ST_RUN} pfc_state_t;
endpackage

// [hw/pfc_config_master.sv]
// How it works
// - While restart is low, every flash bus output and the clock are tri-stated.
// - Chip-enable high gives the flash bus away; low lets this block own it.
// - No flash wait input is used; read pacing comes from the own clock only.
// - The configuration clock is made here by dividing the internal clock.
// - Configuration clock period stays within 50 ns except while a full FIFO holds the clock high and stretches it.
// - One full 16-bit word is read from flash per configuration clock cycle.
// - The divider is chosen from the typical 33.33 ns period.
// - Reading starts at word address 0x010000 after reset.
// - A test-port instruction may replace the boot address with any address.
`timescale 1ns/1ps

module pfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire logic do_write = in_valid_in && in_ready_out;
  wire logic do_read = out_valid_out && out_ready_in;

  assign in_ready_out = (count_reg != CNT_FULL);
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];

  always_ff @(posedge mclk_in) begin
    if (do_write) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_write) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_read) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_write && !do_read) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_read && !do_write) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module pfc_config_master #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic config_restart_n_in,
  input wire logic chip_enable_in,
  input wire pfc_pkg::pfc_data_t flash_data_in,
  input wire logic boot_addr_load_in,
  input wire pfc_pkg::pfc_addr_t boot_addr_in,
  output pfc_pkg::pfc_flash_bus_t flash_bus_out,
  output logic flash_bus_oe_out,
  output logic config_clock_out,
  output logic config_clock_oe_out,
  output logic word_valid_out,
  output pfc_pkg::pfc_word_t word_out,
  input wire logic word_ready_in
);
  import pfc_pkg::*;

  logic restart_meta_reg;
  logic restart_sync_reg;
  logic ce_meta_reg;
  logic ce_sync_reg;
  pfc_data_t data_meta_reg;
  pfc_data_t data_sync_reg;
  pfc_state_t state_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic clk_reg;
  logic bus_oe_reg;
  pfc_addr_t addr_reg;
  pfc_addr_t boot_addr_reg;
  logic out_valid_reg;
  pfc_word_t out_word_reg;
  pfc_word_t fifo_out_word;
  logic fifo_in_ready;
  logic fifo_out_valid;

  // Pins cross into the system clock domain through two flip-flops
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      restart_meta_reg <= 1'b0;
      restart_sync_reg <= 1'b0;
      ce_meta_reg <= 1'b1;
      ce_sync_reg <= 1'b1;
      data_meta_reg <= '0;
      data_sync_reg <= '0;
    end else begin
      restart_meta_reg <= config_restart_n_in;
      restart_sync_reg <= restart_meta_reg;
      ce_meta_reg <= chip_enable_in;
      ce_sync_reg <= ce_meta_reg;
      data_meta_reg <= flash_data_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  wire logic bus_granted = restart_sync_reg && !ce_sync_reg;
  wire logic running = (state_reg == ST_RUN);
  wire logic start = (state_reg == ST_RELEASED) && bus_granted;
  wire logic stop = running && !bus_granted;
  // No wait input exists: the word is taken at the fixed end of each period
  wire logic capture = running && bus_granted && (phase_reg == PHASE_LAST);
  wire logic push = capture && fifo_in_ready;
  wire logic stall = capture && !fifo_in_ready;
  wire logic [PHASE_W-1:0] phase_inc = phase_reg + 1'b1;
  wire pfc_addr_t addr_inc = addr_reg + 1'b1;
  wire pfc_word_t capture_word = '{addr: addr_reg, data: data_sync_reg};
  wire logic fifo_out_ready = !out_valid_reg || word_ready_in;

  // Boot address survives restarts; only a full reset restores the default
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_addr_reg <= BOOT_ADDR_DEFAULT;
    end else if (boot_addr_load_in) begin
      boot_addr_reg <= boot_addr_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_RELEASED;
      bus_oe_reg <= 1'b0;
    end else if (start) begin
      state_reg <= ST_RUN;
      bus_oe_reg <= 1'b1;
    end else if (stop) begin
      state_reg <= ST_RELEASED;
      bus_oe_reg <= 1'b0;
    end
  end

  // Clock low for the first half-period, high for the second; a full FIFO
  // holds it high, which stretches the period but never adds an edge.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= PHASE_ZERO;
      clk_reg <= 1'b0;
    end else if (start || stop || push) begin
      phase_reg <= PHASE_ZERO;
      clk_reg <= 1'b0;
    end else if (running && !capture) begin
      phase_reg <= phase_inc;
      clk_reg <= (phase_inc >= PHASE_HIGH);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_reg <= BOOT_ADDR_DEFAULT;
    end else if (start) begin
      addr_reg <= boot_addr_reg;
    end else if (push) begin
      addr_reg <= addr_inc;
    end
  end

  pfc_fifo #(
    .WIDTH($bits(pfc_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(capture),
    .in_ready_out(fifo_in_ready),
    .in_data_in(capture_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_word)
  );

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_valid_reg <= 1'b0;
      out_word_reg <= '0;
    end else if (fifo_out_ready) begin
      out_valid_reg <= fifo_out_valid;
      out_word_reg <= fifo_out_word;
    end
  end

  // Flash stays in asynchronous read: chip, output and latch enables held active while running, high when released
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_bus_out <= FLASH_BUS_IDLE;
    end else begin
      flash_bus_out <= '{addr: (start ? boot_addr_reg : (push ? addr_inc : addr_reg)),
                         ce_n: !(running || start), oe_n: !(running || start),
                         we_n: 1'b1, avd_n: !(running || start), rst_n: 1'b1};
    end
  end

  assign flash_bus_oe_out = bus_oe_reg;
  assign config_clock_out = clk_reg;
  assign config_clock_oe_out = bus_oe_reg;
  assign word_valid_out = out_valid_reg;
  assign word_out = out_word_reg;

  AST_RESTART_RELEASES: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !restart_sync_reg |=> !flash_bus_oe_out && !config_clock_oe_out)
    else $error("bus still driven while restart is low");
  AST_CE_GIVES_BUS: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ce_sync_reg |=> !flash_bus_oe_out)
    else $error("bus driven while chip-enable is high");
  AST_CLOCK_LOW_WHEN_RELEASED: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !bus_oe_reg |-> !clk_reg)
    else $error("configuration clock high while bus released");
  AST_CLOCK_LOW_HALF: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $fell(clk_reg) && bus_oe_reg |-> !clk_reg[*2] ##1 (clk_reg || !bus_oe_reg))
    else $error("configuration clock low half not two cycles");
  AST_WORD_ON_HIGH_CLOCK: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    push |-> clk_reg ##1 !clk_reg)
    else $error("word not taken once per clock period");
  AST_ADDR_STEPS: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    push |=> addr_reg == pfc_addr_t'($past(addr_reg) + 1'b1))
    else $error("address did not advance by one word");
  AST_STALL_HOLDS: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    stall |=> ($stable(addr_reg) && clk_reg) || !bus_oe_reg)
    else $error("stall lost the address or clock level");
  AST_START_AT_BOOT: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(bus_oe_reg) |-> addr_reg == boot_addr_reg &&
      flash_bus_out.addr == boot_addr_reg)
    else $error("reading did not start at boot address");
  AST_BOOT_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    boot_addr_load_in |=> boot_addr_reg == $past(boot_addr_in))
    else $error("boot address not replaced");
  // Clock is low for the two cycles after the bus returns, then rises,
  // unless the grant was lost again straight away
  AST_REGRANT: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start |=> flash_bus_oe_out && !flash_bus_out.ce_n ##1 !config_clock_out
      ##1 (config_clock_out || !flash_bus_oe_out))
    else $error("bus not taken back after restart");

  COV_START: cover property (@(posedge mclk_in) disable iff (!rst_n_in) start);
  COV_PUSH_RUN: cover property (@(posedge mclk_in) disable iff (!rst_n_in) push ##4 push);
  COV_STALL: cover property (@(posedge mclk_in) disable iff (!rst_n_in) stall);
  COV_HANDOFF: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    running && ce_sync_reg ##1 !running);
endmodule

// [sim/pfc_flash_model.sv]
`timescale 1ns/1ps
module pfc_flash_model (
  input wire pfc_pkg::pfc_flash_bus_t bus_in,
  input wire logic bus_oe_in,
  input wire logic slow_in,
  output pfc_pkg::pfc_data_t data_out
);
  import pfc_pkg::*;
  pfc_data_t pins = 16'hC3A5;
  logic sel;
  assign sel = bus_oe_in && !bus_in.ce_n && !bus_in.oe_n;
  assign data_out = pins;
  // No wait line is offered: access time is 3 ns, or 15 ns when slow_in is set, and the reader has to fit it
  always @(bus_in or sel or slow_in) begin
    // Pins in transit or released show the inverse, so a stale word never matches
    pins = ~pins;
    if (sel) begin
      pins <= #(slow_in ? 15 : 3) bus_in.addr[15:0] ^ {bus_in.addr[23:16], 8'h5A};
    end
  end
endmodule

// [sim/test_pfc_config_master.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, g, e); end end
module test_pfc_config_master;
  import pfc_pkg::*;
  logic mclk_in = 0, rst_n_in = 0, config_restart_n_in = 0, chip_enable_in = 0;
  logic boot_addr_load_in = 0, word_ready_in = 0, slow = 0, last_clk = 0;
  logic flash_bus_oe_out, config_clock_out, config_clock_oe_out, word_valid_out;
  pfc_addr_t boot_addr_in = '0;
  pfc_addr_t rnd_addr;
  pfc_data_t flash_data_in;
  pfc_flash_bus_t flash_bus_out;
  pfc_word_t word_out, exp_w;
  pfc_word_t exp_q[$];
  int err_total = 0, checks_done = 0, rmode = 1, per_cnt = 0;

  pfc_config_master #(.FIFO_DEPTH(8)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .config_restart_n_in(config_restart_n_in), .chip_enable_in(chip_enable_in),
    .flash_data_in(flash_data_in), .boot_addr_load_in(boot_addr_load_in),
    .boot_addr_in(boot_addr_in), .flash_bus_out(flash_bus_out),
    .flash_bus_oe_out(flash_bus_oe_out), .config_clock_out(config_clock_out),
    .config_clock_oe_out(config_clock_oe_out), .word_valid_out(word_valid_out),
    .word_out(word_out), .word_ready_in(word_ready_in));
  pfc_flash_model flash_u (.bus_in(flash_bus_out), .bus_oe_in(flash_bus_oe_out),
    .slow_in(slow), .data_out(flash_data_in));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // Consumer: 1 always ready, 0 random, 2 stalled
  always @(posedge mclk_in)
    word_ready_in <= (rmode == 1) || (rmode == 0 && $urandom_range(1, 0) == 1);

  always @(posedge mclk_in) begin
    if (word_valid_out === 1'b1 && word_ready_in === 1'b1 && exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      `CHK(word_out, exp_w)
    end
  end

  // Clock period is only meaningful while the consumer never stalls it
  always @(posedge mclk_in) begin
    if (config_clock_oe_out !== 1'b1) begin
      per_cnt <= 0;
    end else if (config_clock_out === 1'b1 && last_clk === 1'b0) begin
      if (per_cnt > 0 && rmode == 1) begin
        `CHK(per_cnt <= CFG_CLK_MAX_CYC, 1'b1)
        `CHK(per_cnt, CFG_CLK_DIV)
      end
      per_cnt <= 1;
    end else if (per_cnt > 0) begin
      per_cnt <= per_cnt + 1;
    end
    last_clk <= config_clock_out;
  end

  task automatic results();
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic run_cfg(input pfc_addr_t a, input int n, input bit stall);
    int k;
    pfc_addr_t w;
    for (int i = 0; i < n; i++) begin
      w = a + pfc_addr_t'(i);
      exp_q.push_back('{addr: w, data: w[15:0] ^ {w[23:16], 8'h5A}});
    end
    @(posedge mclk_in);
    config_restart_n_in <= 1'b1;
    if (stall) begin
      rmode <= 2;
      repeat (80) @(posedge mclk_in);
      repeat (8) begin
        @(posedge mclk_in);
        #1;
        `CHK(config_clock_out, 1'b1)
      end
      rmode <= 0;
    end
    k = 0;
    while (exp_q.size() > 0 && k < n * 60) begin
      @(posedge mclk_in);
      k++;
    end
    `CHK(exp_q.size(), 0)
  endtask

  task automatic release_bus();
    @(posedge mclk_in);
    config_restart_n_in <= 1'b0;
    rmode <= 1;
    repeat (60) @(posedge mclk_in); // Low for 600 ns
    #1;
    `CHK(flash_bus_oe_out, 1'b0)
    `CHK(config_clock_oe_out, 1'b0)
  endtask

  task automatic load_boot(input pfc_addr_t a);
    @(posedge mclk_in);
    boot_addr_load_in <= 1'b1;
    boot_addr_in <= a;
    @(posedge mclk_in);
    boot_addr_load_in <= 1'b0;
  endtask

  initial begin
    #300000;
    err_total++;
    results();
  end

  initial begin
    void'($urandom(43410));
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    run_cfg(24'h010000, 40, 0);
    release_bus();
    slow <= 1'b1;
    rmode <= 0;
    run_cfg(24'h010000, 30, 0);
    release_bus();
    load_boot(24'hFFFFFE);
    run_cfg(24'hFFFFFE, 12, 1);
    release_bus();
    @(posedge mclk_in);
    chip_enable_in <= 1'b1;
    config_restart_n_in <= 1'b1;
    repeat (30) @(posedge mclk_in);
    #1;
    `CHK(flash_bus_oe_out, 1'b0)
    // Chip-enable high keeps the bus free here; dropping it while restart is still high grants the bus for one cycle
    @(posedge mclk_in);
    chip_enable_in <= 1'b0;
    release_bus();
    rnd_addr = pfc_addr_t'($urandom());
    load_boot(rnd_addr);
    run_cfg(rnd_addr, 10, 0);
    results();
  end
endmodule
